/* verilog/fdcrp_consts.vh */
`ifndef FDCRP_CONSTS_VH
`define FDCRP_CONSTS_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define FDCRP_ADDR_CMD 4'h0
`define FDCRP_ADDR_PERP 4'h4
`define FDCRP_ADDR_STAT 4'h8
`define FDCRP_ADDR_SRESET 4'hC
// ****************************************
// Command codes and fields
// ****************************************
`define FDCRP_OP_VERSION 3'h1
`define FDCRP_OP_RELSEEK 3'h2
`define FDCRP_OP_PERP 3'h3
`define FDCRP_OP_SENSE 3'h4
`define FDCRP_VERSION_DEFAULT 8'h5A
`define FDCRP_ST0_EC_BIT 4
`define FDCRP_ST0_SE_BIT 5
`define FDCRP_IC_NORMAL 2'h0
`define FDCRP_IC_ABNORMAL 2'h1
`define FDCRP_IC_POLL 2'h3
// ****************************************
// Gap2 byte counts
// ****************************************
`define FDCRP_GAP2_LEN_1M 8'h29
`define FDCRP_GAP2_LEN_STD 8'h16
`define FDCRP_OSC_AFTER_STD 8'h18
`define FDCRP_OSC_AFTER_1M 8'h2B
`define FDCRP_WG_IN_GAP2_1M 8'h26
`define FDCRP_WG_IN_GAP2_500K 8'h13
`define FDCRP_WG_IN_GAP2_NONE 8'h00
`define FDCRP_RATE_1M 2'h3
`define FDCRP_RATE_500K 2'h2
`endif

/* verilog/fdcrp_step_gen.v */
`timescale 1ns/100ps
// ****************************************
// Step pulse spacing timer
// ****************************************
module fdcrp_step_gen #(
  parameter CW = 20
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire start,
  input wire [CW-1:0] interval,
  // Tick out
  output reg tick
);
  reg [CW-1:0] cnt_reg;

  always @(posedge aclk) begin
    if (!aresetn || start) begin
      cnt_reg <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (cnt_reg >= interval) begin
      cnt_reg <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

/* verilog/fdcrp_cmd.v */
`timescale 1ns/100ps
`include "fdcrp_consts.vh"
// How it works
// R1 - Version command returns one fixed identification byte at once.
// R2 - Relative seek coded like seek; differs in opcode and direction bit.
// R3 - Direction 0 steps outward, 1 steps inward.
// R4 - Issues exactly the requested count (up to 255) without cylinder compare.
// R5 - Only one relative seek at a time; new one refused while busy.
// R6 - Outward step past track zero sets equipment check, bit 4 of status 0.
// R7 - Present cylinder becomes old plus count, modulo 256; code subtracts the count for outward seeks.
// R8 - Other commands use present cylinder; recalibrate uses track zero only.
// R9 - After reset mode is conventional, both mode bits zero.
// R10 - Host keeps perpendicular mode consistent with programmed data rate.
// R11 - Mode bits decode: 00 conv, gap 500k perp, wg-only conv, 11 1M perp.
// R12 - Format Gap2 is 41 bytes in 1M perpendicular, else 22.
// R13 - Oscillator enable after 24 bytes conventional, 43 in 1M perpendicular.
// R14 - Conventional write asserts write gate at sync field start.
// R15 - Perpendicular write gate starts in Gap2: 38 bytes 1M, 19 at 500k.
// R16 - With mode bits zero, per-drive bits select perpendicular by data rate.
// R17 - Perpendicular drives use zero precompensation, others programmed value; code keeps the programmed value when the mode bits select perpendicular.
// R18 - Per-drive bits written only with overwrite set, ignored if mode set.
// R19 - Software reset clears only the two mode bits.
// R20 - Hardware reset clears mode bits and all per-drive bits.
// R21 - Relative seek end raises interrupt; sense interrupt clears and reports.
// R22 - Step pulses spaced by programmed step interval.
// R23 - Seek ends normally after all steps, setting seek end flag.
module fdcrp_cmd #(
  parameter [7:0] VERSION_ID = `FDCRP_VERSION_DEFAULT, // Arbitrary value
  parameter CW = 20
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Timing and drive selection from the rest of the controller
  input wire [CW-1:0] step_interval,
  input wire [1:0] data_rate,
  input wire [1:0] drive_sel,
  input wire [7:0] precomp_prog,
  // Drive pins
  input wire track_zero_indication,
  output reg step_out,
  output reg dir_out,
  // Format and read/write timing
  output reg [7:0] gap2_len,
  output reg [7:0] osc_enable_after,
  output reg [7:0] write_gate_timing_bit_gap2_bytes,
  output reg [7:0] precomp_eff,
  output reg perp_active,
  // Interrupt to host
  output reg fdc_int
);
  // ****************************************
  // Bus slave
  // ****************************************
  reg aw_held_reg;
  reg w_held_reg;
  reg [3:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire wr_go;
  wire rd_go;
  wire wr_ok;
  assign wr_ok = (awaddr_reg == `FDCRP_ADDR_CMD) || (awaddr_reg == `FDCRP_ADDR_PERP) ||
    (awaddr_reg == `FDCRP_ADDR_SRESET);

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_cmd;
  wire wr_perp;
  wire wr_sreset;
  assign wr_cmd = wr_go && awaddr_reg == `FDCRP_ADDR_CMD && wstrb_reg[0];
  assign wr_perp = wr_go && awaddr_reg == `FDCRP_ADDR_PERP && wstrb_reg[0];
  assign wr_sreset = wr_go && awaddr_reg == `FDCRP_ADDR_SRESET && wstrb_reg[0] &&
    wdata_reg[0];

  // ****************************************
  // Perpendicular mode state
  // ****************************************
  reg gap_bit_reg;
  reg write_gate_timing_bit_reg;
  reg [3:0] per_drive_perp_bits_reg;
  wire overwrite_enable_bit;
  assign overwrite_enable_bit = wdata_reg[7];

  always @(posedge aclk) begin
    if (!aresetn) begin
      gap_bit_reg <= 1'b0; // R9 R20
      write_gate_timing_bit_reg <= 1'b0;
      per_drive_perp_bits_reg <= 4'h0;
    end else if (wr_sreset) begin
      gap_bit_reg <= 1'b0; // R19
      write_gate_timing_bit_reg <= 1'b0;
    end else if (wr_perp) begin
      gap_bit_reg <= wdata_reg[1];
      write_gate_timing_bit_reg <= wdata_reg[0];
      if (overwrite_enable_bit) begin
        per_drive_perp_bits_reg <= wdata_reg[5:2]; // R18
      end
    end
  end

  // ****************************************
  // Mode decode and Gap2 timing
  // ****************************************
  reg drive_perp;
  reg mode_1m;
  reg mode_500k;
  always @* begin
    drive_perp = !gap_bit_reg && !write_gate_timing_bit_reg &&
      per_drive_perp_bits_reg[drive_sel]; // R18 R16
    mode_1m = (gap_bit_reg && write_gate_timing_bit_reg) ||
      (drive_perp && data_rate == `FDCRP_RATE_1M); // R11 R16
    mode_500k = (gap_bit_reg && !write_gate_timing_bit_reg) ||
      (drive_perp && data_rate != `FDCRP_RATE_1M); // R11 R16
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      gap2_len <= `FDCRP_GAP2_LEN_STD;
      osc_enable_after <= `FDCRP_OSC_AFTER_STD;
      write_gate_timing_bit_gap2_bytes <= `FDCRP_WG_IN_GAP2_NONE;
      precomp_eff <= 8'h00;
      perp_active <= 1'b0;
    end else begin
      gap2_len <= mode_1m ? `FDCRP_GAP2_LEN_1M : `FDCRP_GAP2_LEN_STD; // R12
      osc_enable_after <= mode_1m ? `FDCRP_OSC_AFTER_1M : `FDCRP_OSC_AFTER_STD; // R13
      if (mode_1m) begin
        write_gate_timing_bit_gap2_bytes <= `FDCRP_WG_IN_GAP2_1M; // R15
      end else if (mode_500k) begin
        write_gate_timing_bit_gap2_bytes <= `FDCRP_WG_IN_GAP2_500K; // R15
      end else begin
        write_gate_timing_bit_gap2_bytes <= `FDCRP_WG_IN_GAP2_NONE; // R14
      end
      precomp_eff <= drive_perp ? 8'h00 : precomp_prog; // R17
      perp_active <= mode_1m || mode_500k;
    end
  end

  // ****************************************
  // Track zero synchroniser
  // ****************************************
  reg tz_meta_reg;
  reg tz_sync_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      tz_meta_reg <= 1'b0;
      tz_sync_reg <= 1'b0;
    end else begin
      tz_meta_reg <= track_zero_indication;
      tz_sync_reg <= tz_meta_reg;
    end
  end

  // ****************************************
  // Command engine
  // ****************************************
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_STEP = 4'b0010;
  localparam [3:0] S_WAIT = 4'b0100;
  localparam [3:0] S_DONE = 4'b1000;
  reg [3:0] state_reg;
  reg [7:0] steps_left_reg;
  reg [7:0] present_cylinder;
  reg [7:0] result_reg;
  reg result_valid_reg;
  reg seek_end_flag;
  reg equipment_check_flag;
  reg [1:0] int_code_reg;
  reg [1:0] seek_drive_reg;
  wire tick;
  wire [2:0] op;
  assign op = wdata_reg[2:0];
  wire start_seek;
  assign start_seek = wr_cmd && op == `FDCRP_OP_RELSEEK && state_reg == S_IDLE; // R5 R2
  wire [7:0] status_reg_zero;
  assign status_reg_zero = {int_code_reg, seek_end_flag, equipment_check_flag, 2'h0,
    seek_drive_reg};

  fdcrp_step_gen #(
    .CW(CW)
  ) u_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_seek),
    .interval(step_interval),
    .tick(tick)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      steps_left_reg <= 8'h00;
      present_cylinder <= 8'h00;
      result_reg <= 8'h00;
      result_valid_reg <= 1'b0;
      seek_end_flag <= 1'b0;
      equipment_check_flag <= 1'b0;
      int_code_reg <= `FDCRP_IC_POLL;
      seek_drive_reg <= 2'h0;
      step_out <= 1'b0;
      dir_out <= 1'b0;
      fdc_int <= 1'b0;
    end else begin
      step_out <= 1'b0;
      if (wr_cmd && op == `FDCRP_OP_VERSION) begin
        result_reg <= VERSION_ID; // R1
        result_valid_reg <= 1'b1;
      end else if (wr_cmd && op == `FDCRP_OP_SENSE && !start_seek) begin
        result_reg <= status_reg_zero; // R21
        result_valid_reg <= 1'b1;
        fdc_int <= 1'b0;
        seek_end_flag <= 1'b0;
        equipment_check_flag <= 1'b0;
        int_code_reg <= `FDCRP_IC_POLL;
      end
      case (state_reg)
        S_IDLE: begin
          if (start_seek) begin
            dir_out <= wdata_reg[3]; // R3
            steps_left_reg <= wdata_reg[15:8]; // R4
            seek_drive_reg <= drive_sel;
            state_reg <= (wdata_reg[15:8] == 8'h00) ? S_DONE : S_WAIT;
          end
        end
        S_WAIT: begin
          if (tick) begin
            state_reg <= S_STEP; // R22
          end
        end
        S_STEP: begin
          if (!dir_out && tz_sync_reg) begin
            equipment_check_flag <= 1'b1; // R6
            seek_end_flag <= 1'b1;
            int_code_reg <= `FDCRP_IC_ABNORMAL;
            fdc_int <= 1'b1; // R21
            state_reg <= S_IDLE;
          end else begin
            step_out <= 1'b1;
            present_cylinder <= dir_out ? present_cylinder + 8'h01 :
              present_cylinder - 8'h01; // R7 R8
            steps_left_reg <= steps_left_reg - 8'h01;
            state_reg <= (steps_left_reg == 8'h01) ? S_DONE : S_WAIT; // R4
          end
        end
        S_DONE: begin
          seek_end_flag <= 1'b1; // R23
          int_code_reg <= `FDCRP_IC_NORMAL;
          fdc_int <= 1'b1; // R21
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `FDCRP_ADDR_CMD: s_axi_rdata <= {23'h0, result_valid_reg, result_reg};
        `FDCRP_ADDR_PERP: s_axi_rdata <= {26'h0, per_drive_perp_bits_reg, gap_bit_reg,
          write_gate_timing_bit_reg};
        `FDCRP_ADDR_STAT: s_axi_rdata <= {12'h0, state_reg != S_IDLE, fdc_int, 2'h0,
          present_cylinder, status_reg_zero};
        `FDCRP_ADDR_SRESET: s_axi_rdata <= 32'h00000000;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* tb/fdcrp_drive_model.sv */
`timescale 1ns/100ps
// ****
// Head position of the drive
// ****
module fdcrp_drive_model (
  // Drive pins
  input wire aclk,
  input wire step_out,
  input wire dir_out,
  output logic track_zero_indication,
  // Observation
  output int track
);
  initial track = 0;
  always @(posedge aclk) begin
    if (step_out && dir_out) begin
      track <= track + 1;
    end else if (step_out && track > 0) begin
      track <= track - 1;
    end
  end
  assign track_zero_indication = (track == 0);
endmodule

/* tb/fdcrp_cmd_properties.sv */
`timescale 1ns/100ps
// ****
// Port checks
// ****
module fdcrp_cmd_properties (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_arready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  // Drive and timing outputs
  input wire step_out,
  input wire dir_out,
  input wire [7:0] gap2_len,
  input wire [7:0] osc_enable_after,
  input wire [7:0] write_gate_timing_bit_gap2_bytes,
  input wire [7:0] precomp_eff,
  input wire [7:0] precomp_prog,
  input wire perp_active,
  input wire fdc_int
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_step_one_cycle: assert property (step_out |=> !step_out)
    else $error("step pulse longer than one cycle");
  a_dir_steady: assert property (step_out |-> $stable(dir_out))
    else $error("direction changed with a step");
  a_gap_osc_pair: assert property ((gap2_len == 8'h29) == (osc_enable_after == 8'h2B))
    else $error("gap2 length and oscillator delay disagree");
  a_gap_std: assert property (gap2_len != 8'h29 |-> gap2_len == 8'h16)
    else $error("gap2 length not standard");
  a_gap_write_gate_timing_bit: assert property (gap2_len == 8'h29 |-> write_gate_timing_bit_gap2_bytes == 8'h26)
    else $error("write gate bytes wrong in fast mode");
  a_conv_precomp: assert property ($past(aresetn) && !perp_active |->
    precomp_eff == $past(precomp_prog))
    else $error("conventional drive lost programmed precompensation");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_b_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_int_no_step: assert property (fdc_int |-> !step_out)
    else $error("step after seek end");
endmodule
bind fdcrp_cmd fdcrp_cmd_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .step_out(step_out), .dir_out(dir_out), .gap2_len(gap2_len),
  .osc_enable_after(osc_enable_after), .write_gate_timing_bit_gap2_bytes(write_gate_timing_bit_gap2_bytes),
  .precomp_eff(precomp_eff), .precomp_prog(precomp_prog), .perp_active(perp_active),
  .fdc_int(fdc_int));

/* tb/tb_fdc_relseek_perp_cmds.sv */
`timescale 1ns/100ps
`include "fdcrp_consts.vh"
// ****
// Command engine bench
// ****
module tb_fdc_relseek_perp_cmds;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, rd;
  logic [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [19:0] step_interval;
  logic [1:0] data_rate, drive_sel;
  logic [7:0] precomp_prog;
  wire track_zero_indication, step_out, dir_out, perp_active, fdc_int;
  wire [7:0] gap2_len, osc_enable_after, write_gate_timing_bit_gap2_bytes, precomp_eff;
  int track, i, bad_count = 0, check_count = 0;
  logic [23:0] mode_exp [4] = '{24'h161800, 24'h161800, 24'h161813, 24'h292B26};
  // Identification byte is arbitrary
  fdcrp_cmd #(.VERSION_ID(8'hA5), .CW(20)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .step_interval(step_interval),
    .data_rate(data_rate), .drive_sel(drive_sel), .precomp_prog(precomp_prog),
    .track_zero_indication(track_zero_indication), .step_out(step_out), .dir_out(dir_out),
    .gap2_len(gap2_len), .osc_enable_after(osc_enable_after), .write_gate_timing_bit_gap2_bytes(write_gate_timing_bit_gap2_bytes),
    .precomp_eff(precomp_eff), .perp_active(perp_active), .fdc_int(fdc_int));
  fdcrp_drive_model u_drive (.aclk(aclk), .step_out(step_out), .dir_out(dir_out),
    .track_zero_indication(track_zero_indication), .track(track));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Seek, optionally a second one while busy, then status and sense
  task seek(input logic dir, input logic [7:0] cnt, input logic again,
            input logic [15:0] st, input logic [15:0] m, input int trk);
    axi_wr(`FDCRP_ADDR_CMD, {16'h0000, cnt, 4'h0, dir, `FDCRP_OP_RELSEEK});
    if (again) axi_wr(`FDCRP_ADDR_CMD, {16'h0000, cnt, 4'h0, dir, `FDCRP_OP_RELSEEK});
    if (again) check(rsp, 2'h0);
    while (fdc_int !== 1'b1) begin
      @(posedge aclk);
    end
    axi_rd(`FDCRP_ADDR_STAT);
    check(rd[15:0] & m, st);
    check(track, trk);
    axi_wr(`FDCRP_ADDR_CMD, {29'h0, `FDCRP_OP_SENSE});
    repeat (2) @(posedge aclk);
    check(fdc_int, 1'b0);
  endtask
  task finish_test;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    step_interval = 20'h00007;
    data_rate = `FDCRP_RATE_1M;
    drive_sel = 2'h0;
    precomp_prog = 8'h3C;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`FDCRP_ADDR_STAT);
    check(rd[7:0], 8'hC0);
    check({gap2_len, osc_enable_after, write_gate_timing_bit_gap2_bytes}, 24'h161800);
    axi_rd(`FDCRP_ADDR_PERP);
    check(rd[7:0], 8'h00);
    axi_wr(`FDCRP_ADDR_CMD, {29'h0, `FDCRP_OP_VERSION});
    axi_rd(`FDCRP_ADDR_CMD);
    check({rsp, rd[8:0]}, 11'h1A5);
    for (i = 0; i < 4; i++) begin
      axi_wr(`FDCRP_ADDR_PERP, 32'(i));
      repeat (3) @(posedge aclk);
      check({gap2_len, osc_enable_after, write_gate_timing_bit_gap2_bytes}, mode_exp[i]);
    end
    axi_wr(`FDCRP_ADDR_PERP, 32'h00000088);
    drive_sel <= 2'h1;
    repeat (3) @(posedge aclk);
    check({perp_active, write_gate_timing_bit_gap2_bytes, precomp_eff}, 17'h12600);
    data_rate <= `FDCRP_RATE_500K;
    repeat (3) @(posedge aclk);
    check(write_gate_timing_bit_gap2_bytes, 8'h13);
    drive_sel <= 2'h0;
    repeat (3) @(posedge aclk);
    check({perp_active, write_gate_timing_bit_gap2_bytes, precomp_eff}, 17'h0003C);
    axi_wr(`FDCRP_ADDR_PERP, 32'h00000001);
    axi_rd(`FDCRP_ADDR_PERP);
    check(rd[7:0], 8'h09);
    axi_wr(`FDCRP_ADDR_SRESET, 32'h00000001);
    axi_rd(`FDCRP_ADDR_PERP);
    check(rd[7:0], 8'h08);
    seek(1'b1, 8'h05, 1'b1, 16'h0520, 16'hFFFF, 5);
    seek(1'b1, 8'hFF, 1'b0, 16'h0420, 16'hFFFF, 260);
    seek(1'b0, 8'hFF, 1'b0, 16'h0520, 16'hFFFF, 5);
    seek(1'b0, 8'h0A, 1'b0, 16'h0070, 16'h00FF, 0);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`FDCRP_ADDR_PERP);
    check(rd[7:0], 8'h00);
    finish_test;
  end
endmodule
